// ==== src/mpl_poller.sv ====
/*
 * PHY management poller top: register file on an AHB-Lite slave,
 * background poll of all PHY addresses, link-change watch on two
 * selected PHYs and two queued user access slots.
 * Assumes one clock, a synchronous active-high reset and a single
 * master; the data pin is synchronised here before use.
 */
// Local design decisions: the register addresses and the AHB-Lite register port.
// Notes on behaviour
// RQ1: Enabled device polls every PHY address forever.
// RQ2: Bus clock is divided by software divisor.
// RQ3: Each poll reads the PHY status register.
// RQ4: Answering PHY sets its responder map bit.
// RQ5: Link bit needs answer plus active link.
// RQ6: User reads also update the responder map.
// RQ7: Idle after reset until enable is written.
// RQ8: Preamble sent unless software turns it off.
// RQ9: Two selection registers name monitored PHYs.
// RQ10: Enabled monitored link change sets event bits.
// RQ11: Go bit starts the described slot transaction.
// RQ12: Finish clears go, sets slot completion event.
// RQ13: Masked completion follows set/clear mask registers.
// RQ14: Two slots served one at a time, round-robin.
// RQ15: Software waits for go clear before rewriting.
// RQ16: Acknowledge bit tells whether a read succeeded.
// RQ17: One shared clock line and bidirectional data.
// RQ18: Read done: ack if answered, data stored.
// RQ19: Write request fields written together in one word.
// RQ20: Frame: preamble, start, opcode, addresses, turnaround, data.
// RQ21: Line released on reads; low second turnaround answers.
// RQ22: User requests beat polling at frame boundaries.
`default_nettype none

module mpl_poller (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   output logic MGMT_BUS_CLOCK,
   input wire logic MGMT_DATA_I,
   output logic MGMT_DATA_O,
   output logic MGMT_DATA_OE
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      mpl_pkg::mpl_ctrl_t ctrl;
      logic [31:0] phy_responded_map;
      logic [31:0] link;
      logic [1:0] link_raw;
      logic [1:0] done_raw;
      logic [1:0] done_mask;
      mpl_pkg::mpl_access_t [1:0] acc;
      mpl_pkg::mpl_select_t [1:0] sel;
      logic [4:0] poll_addr;
      logic last_slot;
      logic cur_user;
      logic cur_slot;
      mpl_pkg::mpl_sched_t st;
      logic req;
      logic wr;
      logic [4:0] phy;
      logic [4:0] regadr;
      logic [15:0] wdata;
      logic dph;
      logic dhit;
      logic dwr;
      logic [7:0] daddr;
      logic rd_wait;
      logic [31:0] rdata;
      logic [1:0] sync;
   } mpl_top_state_t;

   mpl_top_state_t s;
   mpl_top_state_t n;

   mpl_frame_if fif ();

   logic mdc_rise;
   logic mdc_fall;

   // ****************************************
   // Register read mux
   // ****************************************
   function automatic logic [31:0] read_reg(input mpl_top_state_t st, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         mpl_pkg::OFS_CONTROL: begin
            r = st.ctrl;
         end
         mpl_pkg::OFS_PHY_RESPONDED_MAP: begin
            r = st.phy_responded_map;
         end
         mpl_pkg::OFS_LINK: begin
            r = st.link;
         end
         mpl_pkg::OFS_LINK_RAW: begin
            r = {30'h0000_0000, st.link_raw};
         end
         mpl_pkg::OFS_LINK_MASKED: begin
            r = {30'h0000_0000, st.link_raw & {st.sel[1].irq_en, st.sel[0].irq_en}}; // RQ10
         end
         mpl_pkg::OFS_DONE_RAW: begin
            r = {30'h0000_0000, st.done_raw};
         end
         mpl_pkg::OFS_DONE_MASKED: begin
            r = {30'h0000_0000, st.done_raw & st.done_mask}; // RQ13
         end
         mpl_pkg::OFS_MASK_SET, mpl_pkg::OFS_MASK_CLEAR: begin
            r = {30'h0000_0000, st.done_mask};
         end
         mpl_pkg::OFS_ACCESS0: begin
            r = st.acc[0];
         end
         mpl_pkg::OFS_ACCESS1: begin
            r = st.acc[1];
         end
         mpl_pkg::OFS_SELECT0: begin
            r = st.sel[0];
         end
         mpl_pkg::OFS_SELECT1: begin
            r = st.sel[1];
         end
         default: begin
            r = 32'h0000_0000;
         end
      endcase
      return r;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [1:0] pend;
      logic slot;
      logic new_link;
      logic [31:0] w;
      pend = {s.acc[1].go, s.acc[0].go};
      slot = 1'b0;
      new_link = 1'b0;
      w = HWDATA;
      n = s;
      n.req = 1'b0;
      // First flop feeds only the second one
      n.sync = {s.sync[0], MGMT_DATA_I};
      n.rd_wait = 1'b0;

      // Bus address phase; a stalled read holds the pending one
      if (HREADY) begin
         n.dph = HSEL & HTRANS[1];
         n.dhit = HADDR[31:8] == 24'h00_0000;
         n.dwr = HWRITE;
         n.daddr = HADDR[7:0];
         n.rd_wait = HSEL & HTRANS[1] & ~HWRITE;
      end

      // Read data captured one cycle late so a write just before is seen
      if (s.rd_wait) begin
         n.rdata = s.dhit ? read_reg(s, s.daddr) : 32'h0000_0000;
      end

      // Bus write data phase
      if (s.dph && s.dwr && s.dhit) begin
         case (s.daddr)
            mpl_pkg::OFS_CONTROL: begin
               n.ctrl = w; // RQ7
            end
            mpl_pkg::OFS_LINK_RAW: begin
               n.link_raw = s.link_raw & ~w[1:0];
            end
            mpl_pkg::OFS_DONE_RAW: begin
               n.done_raw = s.done_raw & ~w[1:0];
            end
            mpl_pkg::OFS_MASK_SET: begin
               n.done_mask = s.done_mask | w[1:0]; // RQ13
            end
            mpl_pkg::OFS_MASK_CLEAR: begin
               n.done_mask = s.done_mask & ~w[1:0]; // RQ13
            end
            mpl_pkg::OFS_ACCESS0: begin
               n.acc[0] = w; // RQ11
               n.acc[0].ack = s.acc[0].ack;
               n.acc[0].rsv = 3'h0;
            end
            mpl_pkg::OFS_ACCESS1: begin
               n.acc[1] = w; // RQ11
               n.acc[1].ack = s.acc[1].ack;
               n.acc[1].rsv = 3'h0;
            end
            mpl_pkg::OFS_SELECT0: begin
               n.sel[0] = w & mpl_pkg::SELECT_MASK; // RQ9
            end
            mpl_pkg::OFS_SELECT1: begin
               n.sel[1] = w & mpl_pkg::SELECT_MASK; // RQ9
            end
            default: begin
            end
         endcase
      end

      // Scheduler; hardware updates come after bus writes so sets win
      case (s.st)
         mpl_pkg::SCH_IDLE: begin
            if (s.ctrl.enable) begin // RQ7
               n.req = 1'b1;
               n.st = mpl_pkg::SCH_RUN;
               if (pend != 2'b00) begin // RQ22
                  slot = (pend == 2'b11) ? ~s.last_slot : pend[1]; // RQ14
                  n.last_slot = slot;
                  n.cur_slot = slot;
                  n.cur_user = 1'b1;
                  n.wr = s.acc[slot].write;
                  n.phy = s.acc[slot].phy;
                  n.regadr = s.acc[slot].regadr;
                  n.wdata = s.acc[slot].data;
               end else begin
                  n.cur_user = 1'b0;
                  n.wr = 1'b0;
                  n.phy = s.poll_addr; // RQ1
                  n.regadr = mpl_pkg::STATUS_REG; // RQ3
                  n.wdata = 16'h0000;
               end
            end
         end
         mpl_pkg::SCH_RUN: begin
            if (fif.done) begin
               n.st = mpl_pkg::SCH_IDLE;
               if (s.cur_user) begin
                  n.acc[s.cur_slot].go = 1'b0; // RQ12
                  n.done_raw[s.cur_slot] = 1'b1; // RQ12
                  if (!s.wr) begin
                     n.acc[s.cur_slot].ack = fif.ack; // RQ16 RQ18
                     if (fif.ack) begin
                        n.acc[s.cur_slot].data = fif.rdata; // RQ18
                     end
                     n.phy_responded_map[s.phy] = fif.ack; // RQ6
                  end
               end else begin
                  new_link = fif.ack & fif.rdata[mpl_pkg::LINK_BIT];
                  n.phy_responded_map[s.phy] = fif.ack; // RQ4
                  n.link[s.phy] = new_link; // RQ5
                  for (int i = 0; i < 2; i++) begin
                     if (s.sel[i].irq_en && s.sel[i].phy == s.phy
                         && new_link != s.link[s.phy]) begin
                        n.link_raw[i] = 1'b1; // RQ10
                     end
                  end
                  n.poll_addr = s.phy + 5'h01; // RQ1
               end
            end
         end
         default: begin
            n.st = mpl_pkg::SCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         s <= '0;
         s.ctrl <= mpl_pkg::CTRL_RESET;
      end else begin
         s <= n;
      end
   end

   // ****************************************
   // Frame request and serial pins
   // ****************************************
   assign fif.req = s.req;
   assign fif.write = s.wr;
   assign fif.no_pre = s.ctrl.no_preamble; // RQ8
   assign fif.phy = s.phy;
   assign fif.regadr = s.regadr;
   assign fif.wdata = s.wdata;

   // Clock keeps running to finish a frame even if enable drops
   mpl_mdc_gen u_div (
      .clk(SYS_CLK),
      .rst(RST),
      .run(s.ctrl.enable | (s.st == mpl_pkg::SCH_RUN)),
      .divisor(s.ctrl.divisor),
      .mdc(MGMT_BUS_CLOCK), // RQ17
      .rise(mdc_rise),
      .fall(mdc_fall)
   );

   mpl_frame u_frame (
      .clk(SYS_CLK),
      .rst(RST),
      .rise(mdc_rise),
      .fall(mdc_fall),
      .din(s.sync[1]),
      .dout(MGMT_DATA_O), // RQ17
      .doe(MGMT_DATA_OE),
      .f(fif)
   );

   // ****************************************
   // Bus answer
   // ****************************************
   assign HREADYOUT = ~s.rd_wait;
   assign HRDATA = s.rdata;
   assign HRESP = 1'b0;
endmodule

`default_nettype wire

// ==== inc/mpl_pkg.sv ====
/*
 * Constants and types of the PHY management poller: register map,
 * register layouts, frame layout and state encodings.
 * Assumes a 32-bit word-aligned register bus and a 5-bit PHY space.
 */
`default_nettype none

package mpl_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_PHY_RESPONDED_MAP = 8'h08;
   localparam logic [7:0] OFS_LINK = 8'h0C;
   localparam logic [7:0] OFS_LINK_RAW = 8'h10;
   localparam logic [7:0] OFS_LINK_MASKED = 8'h14;
   localparam logic [7:0] OFS_DONE_RAW = 8'h20;
   localparam logic [7:0] OFS_DONE_MASKED = 8'h24;
   localparam logic [7:0] OFS_MASK_SET = 8'h28;
   localparam logic [7:0] OFS_MASK_CLEAR = 8'h2C;
   localparam logic [7:0] OFS_ACCESS0 = 8'h80;
   localparam logic [7:0] OFS_SELECT0 = 8'h84;
   localparam logic [7:0] OFS_ACCESS1 = 8'h88;
   localparam logic [7:0] OFS_SELECT1 = 8'h8C;

   // ****************************************
   // Register layouts
   // ****************************************
   typedef struct packed {
      logic rsv0;
      logic enable;
      logic [8:0] rsv1;
      logic no_preamble;
      logic [3:0] rsv2;
      logic [15:0] divisor;
   } mpl_ctrl_t;

   typedef struct packed {
      logic go;
      logic write;
      logic ack;
      logic [2:0] rsv;
      logic [4:0] regadr;
      logic [4:0] phy;
      logic [15:0] data;
   } mpl_access_t;

   typedef struct packed {
      logic [24:0] rsv0;
      logic irq_en;
      logic rsv1;
      logic [4:0] phy;
   } mpl_select_t;

   localparam logic [31:0] CTRL_RESET = 32'h0000_00FF;
   localparam logic [31:0] SELECT_MASK = 32'h0000_005F;

   // ****************************************
   // Management frame layout
   // ****************************************
   localparam logic [4:0] STATUS_REG = 5'h01;
   localparam logic [3:0] LINK_BIT = 4'h2;
   localparam logic [1:0] FRAME_START = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam logic [6:0] IDX_PREAMBLE = 7'h00;
   localparam logic [6:0] IDX_FRAME = 7'h20;
   localparam logic [6:0] IDX_LAST = 7'h3F;
   localparam logic [4:0] POS_TA = 5'h0E;
   localparam logic [4:0] POS_ACK = 5'h0F;
   localparam logic [4:0] POS_DATA = 5'h10;

   // ****************************************
   // State encodings
   // ****************************************
   typedef enum logic {SCH_IDLE = 1'b0, SCH_RUN = 1'b1} mpl_sched_t;
   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_ARM = 2'b01,
      ENG_SHIFT = 2'b11
   } mpl_eng_t;

endpackage

`default_nettype wire

// ==== inc/mpl_frame_if.sv ====
/*
 * Frame request and result signals between the scheduler and the
 * serial frame engine. Assumes both ends run on the same clock.
 */
`default_nettype none

interface mpl_frame_if;
   logic req;
   logic write;
   logic no_pre;
   logic [4:0] phy;
   logic [4:0] regadr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic ack;
   logic done;

   modport ctl (output req, write, no_pre, phy, regadr, wdata, input rdata, ack, done);
   modport eng (input req, write, no_pre, phy, regadr, wdata, output rdata, ack, done);
endinterface

`default_nettype wire

// ==== src/mpl_mdc_gen.sv ====
/*
 * Management bus clock divider: half period of divisor+1 cycles,
 * with one-cycle rise and fall strobes.
 * Assumes run stays high for a whole frame.
 */
`default_nettype none

module mpl_mdc_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [15:0] divisor,
   output logic mdc,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic [15:0] cnt;
      logic mdc;
      logic rise;
      logic fall;
   } mpl_div_state_t;

   mpl_div_state_t s;
   mpl_div_state_t n;

   always_comb begin
      n = s;
      n.rise = 1'b0;
      n.fall = 1'b0;
      // Stopped clock rests low so no edge leaks out while idle
      if (!run) begin
         n.cnt = 16'h0000;
         n.mdc = 1'b0;
      end else if (s.cnt >= divisor) begin
         n.cnt = 16'h0000;
         n.mdc = ~s.mdc; // RQ2
         n.rise = ~s.mdc;
         n.fall = s.mdc;
      end else begin
         n.cnt = s.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign mdc = s.mdc;
   assign rise = s.rise;
   assign fall = s.fall;
endmodule

`default_nettype wire

// ==== src/mpl_frame.sv ====
/*
 * Serial frame engine: shifts one management frame out on the data
 * line, releases it for read turnaround and data, samples replies.
 * Assumes din is already synchronised and strobes come from the divider.
 */
`default_nettype none

module mpl_frame (
   input wire logic clk,
   input wire logic rst,
   input wire logic rise,
   input wire logic fall,
   input wire logic din,
   output logic dout,
   output logic doe,
   mpl_frame_if.eng f
);
   typedef struct packed {
      mpl_pkg::mpl_eng_t st;
      logic [6:0] idx;
      logic [31:0] frame;
      logic wr;
      logic ack;
      logic [15:0] rdata;
      logic done;
      logic o;
      logic oe;
   } mpl_eng_state_t;

   mpl_eng_state_t s;
   mpl_eng_state_t n;

   // Preamble bits are ones; frame bits go out MSB first
   function automatic logic frame_bit(input logic [31:0] fr, input logic [6:0] idx);
      return idx[5] ? fr[~idx[4:0]] : 1'b1;
   endfunction

   always_comb begin
      n = s;
      n.done = 1'b0;
      case (s.st)
         mpl_pkg::ENG_IDLE: begin
            if (f.req) begin
               n.frame = {mpl_pkg::FRAME_START,
                          f.write ? mpl_pkg::OP_WRITE : mpl_pkg::OP_READ,
                          f.phy, f.regadr, mpl_pkg::TA_WRITE,
                          f.write ? f.wdata : 16'h0000}; // RQ20
               n.wr = f.write;
               n.idx = f.no_pre ? mpl_pkg::IDX_FRAME : mpl_pkg::IDX_PREAMBLE; // RQ8
               n.ack = 1'b0;
               n.rdata = 16'h0000;
               n.st = mpl_pkg::ENG_ARM;
            end
         end
         mpl_pkg::ENG_ARM: begin
            if (fall) begin
               n.o = frame_bit(s.frame, s.idx);
               n.oe = 1'b1;
               n.st = mpl_pkg::ENG_SHIFT;
            end
         end
         mpl_pkg::ENG_SHIFT: begin
            // Sample at the rising edge, the point the reply is valid
            if (rise && s.idx[5] && !s.wr) begin
               if (s.idx[4:0] == mpl_pkg::POS_ACK) begin
                  n.ack = ~din; // RQ21
               end
               if (s.idx[4:0] >= mpl_pkg::POS_DATA) begin
                  n.rdata = {s.rdata[14:0], din};
               end
            end
            if (fall) begin
               if (s.idx == mpl_pkg::IDX_LAST) begin
                  n.done = 1'b1;
                  n.o = 1'b0;
                  n.oe = 1'b0;
                  n.st = mpl_pkg::ENG_IDLE;
               end else begin
                  n.idx = s.idx + 7'h01;
                  n.o = frame_bit(s.frame, n.idx);
                  n.oe = s.wr | ~n.idx[5] | (n.idx[4:0] < mpl_pkg::POS_TA); // RQ21
               end
            end
         end
         default: begin
            n.st = mpl_pkg::ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign dout = s.o;
   assign doe = s.oe;
   assign f.rdata = s.rdata;
   assign f.ack = s.ack;
   assign f.done = s.done;
endmodule

`default_nettype wire

// ==== test/mpl_poller_assertions.sv ====
/* Port checker for the PHY management poller top.
   Assumes the bench programs divisor 4, so a bus clock phase lasts 5 cycles. */
`default_nettype none
module mpl_poller_assertions (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [31:0] HRDATA,
   input wire logic HRESP,
   input wire logic MGMT_BUS_CLOCK,
   input wire logic MGMT_DATA_I,
   input wire logic MGMT_DATA_O,
   input wire logic MGMT_DATA_OE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ****
   // Register bus
   // ****
   property p_okay; HRESP == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_rd; HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
   a_rd: assert property (p_rd) else $error("read wait state wrong");
   property p_wr; HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT; endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   property p_hrdata; $changed(HRDATA) |-> !$past(HREADYOUT); endproperty
   a_hrdata: assert property (p_hrdata) else $error("read data moved outside a read");
   // ****
   // Management bus
   // ****
   property p_quiet; disable iff (1'b0) RST |=> !MGMT_BUS_CLOCK && !MGMT_DATA_OE; endproperty
   a_quiet: assert property (p_quiet) else $error("bus active in reset");
   property p_dout; $changed(MGMT_DATA_O) |-> !MGMT_BUS_CLOCK; endproperty
   a_dout: assert property (p_dout) else $error("data changed while clock high");
   property p_oe_on; $rose(MGMT_DATA_OE) |-> !MGMT_BUS_CLOCK; endproperty
   a_oe_on: assert property (p_oe_on) else $error("drive began while clock high");
   property p_oe_off; $fell(MGMT_DATA_OE) |-> !MGMT_BUS_CLOCK; endproperty
   a_oe_off: assert property (p_oe_off) else $error("release while clock high");
   property p_mdc_hi; $rose(MGMT_BUS_CLOCK) |=> MGMT_BUS_CLOCK[*4] ##1 !MGMT_BUS_CLOCK; endproperty
   a_mdc_hi: assert property (p_mdc_hi) else $error("clock high phase wrong");
   property p_mdc_lo; $fell(MGMT_BUS_CLOCK) |=> !MGMT_BUS_CLOCK[*4]; endproperty
   a_mdc_lo: assert property (p_mdc_lo) else $error("clock low phase short");
endmodule
bind mpl_poller mpl_poller_assertions chk (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
   .HSIZE, .HWDATA, .HREADY, .HREADYOUT, .HRDATA, .HRESP, .MGMT_BUS_CLOCK, .MGMT_DATA_I,
   .MGMT_DATA_O, .MGMT_DATA_OE);
`default_nettype wire

// ==== test/mpl_phy_model.sv ====
/* Behavioural PHY group on the shared management bus.
   Assumes the bench resolves the data wire with a pull-up. */
`default_nettype none
module mpl_phy_model (
   input wire logic mdc,
   input wire logic mdio,
   input wire logic [31:0] phy_responded_map,
   input wire logic [31:0] link,
   output logic oe,
   output logic dout,
   output logic [25:0] last_wr,
   output logic [5:0] last_pre
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [32];
   logic [11:0] hdr;
   logic [15:0] sh;
   int ones;
   initial begin
      oe = 1'b0;
      dout = 1'b1;
      last_wr = '0;
      last_pre = '0;
      ones = 0;
      hdr = '0;
      sh = '0;
      foreach (mem[i]) mem[i] = 16'h0000;
      forever begin
         @(posedge mdc);
         if (mdio !== 1'b0) begin
            if (ones < 63) ones++;
         end else begin
            last_pre = 6'(ones);
            ones = 0;
            @(posedge mdc);
            repeat (12) begin
               @(posedge mdc);
               hdr = {hdr[10:0], mdio};
            end
            if (hdr[11:10] == 2'b10) begin
               @(posedge mdc);
               if (phy_responded_map[hdr[9:5]]) begin
                  // Status word carries link on bit 2
                  sh = (hdr[4:0] == 5'h01) ? 16'h7809 | {13'h0, link[hdr[9:5]], 2'h0}
                     : mem[hdr[4:0]];
                  @(negedge mdc);
                  oe = 1'b1;
                  dout = 1'b0;
                  repeat (16) begin
                     @(negedge mdc);
                     dout = sh[15];
                     sh = {sh[14:0], 1'b0};
                  end
                  @(negedge mdc);
                  oe = 1'b0;
               end
            end else begin
               repeat (18) begin
                  @(posedge mdc);
                  sh = {sh[14:0], mdio};
               end
               if (phy_responded_map[hdr[9:5]]) begin
                  mem[hdr[4:0]] = sh;
                  last_wr = {hdr[9:0], sh};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/phy_management_poller_bench.sv ====
/* Self-checking bench for the PHY management poller.
   Assumes the checker is bound and the PHY model answers on the wire. */
`default_nettype none
module phy_management_poller_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} mpl_row_t;
   logic sys_clk, rst, hsel, hwrite, hreadyout, mdc, dout, doe, pdout, poe;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, phy_responded_map, link, q;
   logic [25:0] last_wr;
   logic [5:0] last_pre;
   int mismatches = 0, cmp_count = 0, rises = 0, n;
   wire mdio = doe ? dout : (poe ? pdout : 1'b1);
   mpl_row_t rows [8] = '{
      '{mpl_pkg::OFS_CONTROL, 1'b0, 32'h0000_0000, mpl_pkg::CTRL_RESET},
      '{mpl_pkg::OFS_PHY_RESPONDED_MAP, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000},
      '{mpl_pkg::OFS_LINK, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000},
      '{mpl_pkg::OFS_SELECT0, 1'b1, 32'hFFFF_FFFF, mpl_pkg::SELECT_MASK},
      '{mpl_pkg::OFS_SELECT1, 1'b1, 32'h0000_0043, 32'h0000_0043},
      '{mpl_pkg::OFS_MASK_SET, 1'b1, 32'h0000_0003, 32'h0000_0003},
      '{mpl_pkg::OFS_MASK_CLEAR, 1'b1, 32'h0000_0001, 32'h0000_0002},
      '{8'h40, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000}};
   mpl_poller dut (.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(), .MGMT_BUS_CLOCK(mdc),
      .MGMT_DATA_I(mdio), .MGMT_DATA_O(dout), .MGMT_DATA_OE(doe));
   mpl_phy_model phy (.mdc(mdc), .mdio(mdio), .phy_responded_map(phy_responded_map), .link(link), .oe(poe),
      .dout(pdout), .last_wr(last_wr), .last_pre(last_pre));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge mdc) rises++;
   // ****
   // Tasks
   // ****
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      for (int p = 0; p < 2; p++) begin
         k = 0;
         do begin
            @(posedge sys_clk);
            k++;
         end while (hreadyout !== 1'b1 && k < 40);
         if (k >= 40) begin
            mismatches++;
            report_and_stop();
         end
         if (p == 0) begin
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
         end
      end
      q = hrdata;
   endtask
   // Register polls leave gaps so the frames keep running meanwhile
   task automatic wait_for(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 200; i++) begin
         repeat (200) @(posedge sys_clk);
         bus(1'b0, a, 32'h0000_0000);
         if ((q & m) === v) break;
      end
      check(q & m, v);
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = '0;
      hwdata = '0;
      q = '0;
      phy_responded_map = 32'h0000_0025;
      link = 32'h0000_0004;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      foreach (rows[i]) begin
         if (rows[i].w)
            bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0000_0000);
         check(q, rows[i].e);
      end
      check(32'(rises), 32'h0000_0000);
      bus(1'b1, mpl_pkg::OFS_SELECT0, 32'h0000_0042);
      bus(1'b1, mpl_pkg::OFS_CONTROL, 32'h4000_0004);
      wait_for(mpl_pkg::OFS_PHY_RESPONDED_MAP, 32'hFFFF_FFFF, 32'h0000_0025);
      wait_for(mpl_pkg::OFS_LINK, 32'hFFFF_FFFF, 32'h0000_0004);
      check({31'h0, last_pre >= 6'h20}, 32'h0000_0001);
      bus(1'b1, mpl_pkg::OFS_LINK_RAW, 32'h0000_0003);
      bus(1'b0, mpl_pkg::OFS_LINK_MASKED, 32'h0000_0000);
      check(q, 32'h0000_0000);
      link <= 32'h0000_0000;
      wait_for(mpl_pkg::OFS_LINK, 32'hFFFF_FFFF, 32'h0000_0000);
      wait_for(mpl_pkg::OFS_LINK_MASKED, 32'hFFFF_FFFF, 32'h0000_0001);
      bus(1'b1, mpl_pkg::OFS_LINK_RAW, 32'h0000_0003);
      bus(1'b1, mpl_pkg::OFS_ACCESS0, 32'hC085_BEEF);
      wait_for(mpl_pkg::OFS_ACCESS0, 32'h8000_0000, 32'h0000_0000);
      check({6'h00, last_wr}, {6'h00, 5'h05, 5'h04, 16'hBEEF});
      bus(1'b0, mpl_pkg::OFS_DONE_MASKED, 32'h0000_0000);
      check(q, 32'h0000_0000);
      bus(1'b1, mpl_pkg::OFS_DONE_RAW, 32'h0000_0003);
      bus(1'b1, mpl_pkg::OFS_ACCESS0, 32'h8085_0000);
      bus(1'b1, mpl_pkg::OFS_ACCESS1, 32'h8087_0000);
      wait_for(mpl_pkg::OFS_DONE_RAW, 32'hFFFF_FFFF, 32'h0000_0003);
      bus(1'b0, mpl_pkg::OFS_ACCESS0, 32'h0000_0000);
      check(q, 32'h2085_BEEF);
      bus(1'b0, mpl_pkg::OFS_ACCESS1, 32'h0000_0000);
      check(q, 32'h0087_0000);
      bus(1'b0, mpl_pkg::OFS_DONE_MASKED, 32'h0000_0000);
      check(q, 32'h0000_0002);
      bus(1'b0, mpl_pkg::OFS_PHY_RESPONDED_MAP, 32'h0000_0000);
      check(q, 32'h0000_0025);
      bus(1'b1, mpl_pkg::OFS_CONTROL, 32'h4010_0004);
      for (n = 0; n < 4000 && last_pre >= 6'h20; n++) @(posedge sys_clk);
      check({31'h0, last_pre < 6'h20}, 32'h0000_0001);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      n = rises;
      bus(1'b0, mpl_pkg::OFS_CONTROL, 32'h0000_0000);
      check(q, mpl_pkg::CTRL_RESET);
      bus(1'b0, mpl_pkg::OFS_PHY_RESPONDED_MAP, 32'h0000_0000);
      check(q, 32'h0000_0000);
      check(32'(rises - n), 32'h0000_0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
